// *** verilog/sensor_param_pkg.sv ***
package sensor_param_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] addr_prox_hyst = 8'h17;
  localparam logic [7:0] addr_prox_pers = 8'h18;
  localparam logic [7:0] addr_amb_pers = 8'h19;
  localparam logic [7:0] addr_meas_offset = 8'h1A;
  localparam logic [7:0] addr_emit_rec = 8'h1C;
  localparam logic [7:0] addr_ir_rec = 8'h1D;
  localparam logic [7:0] addr_ir_gain = 8'h1E;
  // Five 16-bit thresholds, low byte at even, high byte at odd offset:
  // 0 to 2 proximity, 3 ambient low, 4 ambient high
  localparam logic [7:0] addr_th_base = 8'h20;
  localparam logic [7:0] addr_th_last = 8'h29;
  localparam logic [7:0] addr_irq_status = 8'h30;
  localparam logic [7:0] addr_irq_clear = 8'h31;
  localparam logic [7:0] addr_irq_enable = 8'h32;
  localparam logic [7:0] addr_chan_status = 8'h33;
  localparam logic [7:0] addr_result_lo = 8'h34;
  localparam logic [7:0] addr_result_hi = 8'h35;

  // Values after reset
  localparam logic [7:0] rst_prox_hyst = 8'h48;
  localparam logic [7:0] rst_pers = 8'h03;
  localparam logic [7:0] rst_meas_offset = 8'h80;
  localparam logic [7:0] rst_emit_rec = 8'h00;
  localparam logic [7:0] rst_ir_rec = 8'h70;
  localparam logic [2:0] rst_ir_gain = 3'h0;
  localparam logic [15:0] rst_threshold = 16'h0000;

  // Field positions
  localparam int ir_rec_lsb = 4;
  localparam int ir_rec_msb = 6;

  // Result codes
  localparam logic [15:0] overrange_code = 16'hFFFF;
  localparam logic [15:0] max_valid_code = 16'hFFFE;

  // Channel numbers of a measurement
  localparam logic [2:0] chan_ambient_vis = 3'h3;
  localparam logic [2:0] chan_ambient_ir = 3'h4;

  // Interrupt bits: 3:0 channel status change, 4 overrange seen
  localparam int irq_overrange_bit = 4;

  // ADC clock period and its length in core clocks, rounded up
  localparam int core_period_ns = 10;
  localparam int adc_clock_ns = 50;
  localparam int adc_clock_cycles = (adc_clock_ns + core_period_ns - 1) / core_period_ns;

  typedef enum logic [1:0] {
    rec_idle,
    rec_wait,
    rec_start
  } recovery_state_type;

endpackage

// *** verilog/compressed_decode.sv ***
`timescale 1ns/1ps
// Upper nibble is a shift, lower nibble the mantissa under a hidden one;
// the value is scaled down by 16 so that 0x48 gives 24 and 0x80 gives 256
module compressed_decode (
  // Compressed parameter
  input wire logic [7:0] code,
  // Expanded code count
  output logic [15:0] value
);

  logic [19:0] wide;

  always_comb begin
    wide = {15'h0000, 1'b1, code[3:0]} << code[7:4];
    value = wide[19:4];
  end

endmodule // compressed_decode

// *** verilog/sensor_param_block.sv ***
`timescale 1ns/1ps
module sensor_param_block
  import sensor_param_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Raw measurement from the sequencer
  input wire logic meas_valid,
  input wire logic [2:0] meas_channel,
  input wire logic signed [15:0] meas_delta,
  input wire logic meas_overrange,
  // Conditioned result
  output logic result_valid,
  output logic [2:0] result_channel,
  output logic [15:0] result_value,
  output logic [3:0] channel_status,
  // Ambient IR measurement start
  input wire logic ir_request,
  output logic ir_recovery_busy,
  output logic ir_adc_start,
  output logic [7:0] ir_clock_divide,
  // Interrupt
  output logic irq
);

  // All block state, registered in one always_ff
  typedef struct packed {
    logic [7:0] prox_hyst;
    logic [7:0] prox_pers;
    logic [7:0] amb_pers;
    logic [7:0] meas_offset;
    logic [7:0] emit_rec;
    logic [2:0] ir_rec;
    logic [2:0] ir_gain;
    logic [4:0][15:0] th;
    logic [3:0][7:0] above_hist;
    logic [3:0][7:0] below_hist;
    logic [3:0] chan_status;
    logic [4:0] irq_status;
    logic [4:0] irq_enable;
    logic irq;
    logic [7:0] rd_data;
    logic result_valid;
    logic [2:0] result_channel;
    logic [15:0] result;
    recovery_state_type rec_state;
    logic rec_busy;
    logic [18:0] rec_count;
    logic ir_start;
    logic [7:0] ir_div;
  } state_type;

  localparam state_type reset_state = '{
    prox_hyst: rst_prox_hyst,
    prox_pers: rst_pers,
    amb_pers: rst_pers,
    meas_offset: rst_meas_offset,
    emit_rec: rst_emit_rec,
    ir_rec: rst_ir_rec[ir_rec_msb:ir_rec_lsb],
    ir_gain: rst_ir_gain,
    th: {5{rst_threshold}},
    above_hist: '0,
    below_hist: '0,
    chan_status: '0,
    irq_status: '0,
    irq_enable: '0,
    irq: 1'b0,
    rd_data: 8'h00,
    result_valid: 1'b0,
    result_channel: 3'h0,
    result: 16'h0000,
    rec_state: rec_idle,
    rec_busy: 1'b0,
    rec_count: 19'h00000,
    ir_start: 1'b0,
    ir_div: 8'h01
  };

  state_type s_q;
  state_type s_d;

  logic [15:0] hyst_codes;
  logic [15:0] offset_codes;

  // Fixed exponent-mantissa expansion of the two compressed parameters
  compressed_decode hyst_decode (
    .code(s_q.prox_hyst),
    .value(hyst_codes)
  );

  compressed_decode offset_decode (
    .code(s_q.meas_offset),
    .value(offset_codes)
  );

  // Read view of every register; unmapped offsets and write-only read zero
  function automatic logic [7:0] read_value(input state_type s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a >= addr_th_base && a <= addr_th_last) begin
      // Bytes read live, so a threshold changing between two reads can tear
      if (a[0]) begin
        v = s.th[a[3:1]][15:8];
      end else begin
        v = s.th[a[3:1]][7:0];
      end
    end else begin
      case (a)
        addr_prox_hyst: v = s.prox_hyst;
        addr_prox_pers: v = s.prox_pers;
        addr_amb_pers: v = s.amb_pers;
        addr_meas_offset: v = s.meas_offset;
        addr_emit_rec: v = s.emit_rec;
        addr_ir_rec: v = {1'b0, s.ir_rec, 4'h0};
        addr_ir_gain: v = {5'h00, s.ir_gain};
        addr_irq_status: v = {3'h0, s.irq_status};
        addr_irq_enable: v = {3'h0, s.irq_enable};
        addr_chan_status: v = {4'h0, s.chan_status};
        addr_result_lo: v = s.result[7:0];
        addr_result_hi: v = s.result[15:8];
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction

  // Recovery wait in ADC clocks: 1, then 7, 15 up to 511
  function automatic logic [9:0] recovery_adc_clocks(input logic [2:0] code);
    logic [9:0] v;
    v = 10'h001;
    if (code != 3'h0) begin
      v = (10'h004 << code) - 10'h001;
    end
    return v;
  endfunction

  // Single next-state process for the whole block
  always_comb begin
    logic signed [17:0] sum;
    logic [15:0] res;
    logic [4:0] clear_bits;
    logic [4:0] events;
    logic [16:0] hi_band;
    logic [16:0] lo_band;
    logic is_above;
    logic is_below;
    logic [7:0] mask;
    logic [7:0] new_above;
    logic [7:0] new_below;
    logic [18:0] wait_cycles;
    logic [18:0] adc_clocks;
    logic [1:0] ch;
    sum = 18'sh00000;
    res = 16'h0000;
    clear_bits = 5'h00;
    events = 5'h00;
    hi_band = 17'h00000;
    lo_band = 17'h00000;
    is_above = 1'b0;
    is_below = 1'b0;
    mask = 8'h00;
    new_above = 8'h00;
    new_below = 8'h00;
    wait_cycles = 19'h00000;
    adc_clocks = 19'h00000;
    ch = 2'h0;

    s_d = s_q;
    s_d.result_valid = 1'b0;
    s_d.ir_start = 1'b0;
    // Read data stands only in the cycle after the strobe, zero otherwise
    if (reg_rd) begin
      s_d.rd_data = read_value(s_q, reg_addr);
    end else begin
      s_d.rd_data = 8'h00;
    end

    if (reg_wr) begin
      // Threshold bytes land one at a time; pairs are not latched together
      if (reg_addr >= addr_th_base && reg_addr <= addr_th_last) begin
        if (reg_addr[0]) begin
          s_d.th[reg_addr[3:1]][15:8] = reg_wdata;
        end else begin
          s_d.th[reg_addr[3:1]][7:0] = reg_wdata;
        end
      end else begin
        case (reg_addr)
          addr_prox_hyst: s_d.prox_hyst = reg_wdata;
          addr_prox_pers: s_d.prox_pers = reg_wdata;
          addr_amb_pers: s_d.amb_pers = reg_wdata;
          addr_meas_offset: s_d.meas_offset = reg_wdata;
          addr_emit_rec: s_d.emit_rec = reg_wdata;
          // Bit 7 and bits 3:0 are dropped so stray writes cannot matter
          addr_ir_rec: s_d.ir_rec = reg_wdata[ir_rec_msb:ir_rec_lsb];
          addr_ir_gain: s_d.ir_gain = reg_wdata[2:0];
          addr_irq_clear: clear_bits = reg_wdata[4:0];
          addr_irq_enable: s_d.irq_enable = reg_wdata[4:0];
          default: s_d.irq_enable = s_q.irq_enable;
        endcase
      end
    end

    if (meas_valid) begin
      // Offset lifts small negative differences clear of zero
      sum = 18'(meas_delta) + 18'(signed'({2'b00, offset_codes}));
      if (meas_overrange) begin
        res = overrange_code;
        events[irq_overrange_bit] = 1'b1;
      // Offsets too small for the difference leave zero, not a wrapped value
      end else if (sum < 18'sh00000) begin
        res = 16'h0000;
      end else if (sum > 18'(signed'({2'b00, max_valid_code}))) begin
        // Clamp so a large valid result never reads as overrange
        res = max_valid_code;
      end else begin
        res = sum[15:0];
      end
      // Value, channel and strobe move together
      s_d.result = res;
      s_d.result_valid = 1'b1;
      s_d.result_channel = meas_channel;

      // The IR channel only carries the offset and has no status filter
      if (meas_channel <= chan_ambient_vis) begin
        ch = meas_channel[1:0];
        if (meas_channel == chan_ambient_vis) begin
          // Ambient window: low at slot 3, high at slot 4
          // No hysteresis on this window; its edges are used as written
          is_above = res > s_q.th[4] || res < s_q.th[3];
          is_below = !is_above;
          mask = s_q.amb_pers;
        end else begin
          // Hysteresis widens the band on both sides of the threshold;
          // 17-bit sums so a threshold near full scale cannot wrap
          hi_band = {1'b0, s_q.th[ch]} + {1'b0, hyst_codes};
          lo_band = {1'b0, res} + {1'b0, hyst_codes};
          is_above = {1'b0, res} > hi_band;
          is_below = lo_band < {1'b0, s_q.th[ch]};
          mask = s_q.prox_pers;
        end
        // Histories shift on every sample, whatever the current status
        new_above = {s_q.above_hist[ch][6:0], is_above};
        new_below = {s_q.below_hist[ch][6:0], is_below};
        s_d.above_hist[ch] = new_above;
        s_d.below_hist[ch] = new_below;
        // A zero mask is always met, so status then toggles on every sample
        // Status flips only once the whole masked run agrees
        if (!s_q.chan_status[ch] && (new_above & mask) == mask) begin
          s_d.chan_status[ch] = 1'b1;
          events[ch] = 1'b1;
        end else if (s_q.chan_status[ch] && (new_below & mask) == mask) begin
          s_d.chan_status[ch] = 1'b0;
          events[ch] = 1'b1;
        end
      end
    end

    // A new event outweighs a clear in the same cycle
    s_d.irq_status = s_q.irq_status & ~clear_bits;
    s_d.irq_status = s_d.irq_status | events;
    // Taken from the next state so irq rises with its status bit
    s_d.irq = |(s_d.irq_status & s_d.irq_enable);

    // Gain divides the ADC clock, stretching integration and recovery alike
    s_d.ir_div = 8'h01 << s_q.ir_gain;
    adc_clocks = 19'(recovery_adc_clocks(s_q.ir_rec));
    // Each ADC clock is stretched to a whole number of core cycles,
    // rounded up, so the wait is never shorter than asked for
    wait_cycles = adc_clocks * 19'(adc_clock_cycles);
    wait_cycles = wait_cycles << s_q.ir_gain;

    case (s_q.rec_state)
      rec_idle: begin
        // Requests during a recovery are ignored, not queued
        if (ir_request) begin
          s_d.rec_count = wait_cycles - 19'h00001;
          s_d.rec_state = rec_wait;
        end
      end
      // Counts down to zero, then rec_start raises the one-cycle pulse
      rec_wait: begin
        if (s_q.rec_count == 19'h00000) begin
          s_d.rec_state = rec_start;
        end else begin
          s_d.rec_count = s_q.rec_count - 19'h00001;
        end
      end
      // A request is taken again from the pulse cycle on
      rec_start: begin
        s_d.ir_start = 1'b1;
        s_d.rec_state = rec_idle;
      end
      default: s_d.rec_state = rec_idle;
    endcase

    // Busy is registered so the pin comes straight from a flop
    s_d.rec_busy = s_d.rec_state != rec_idle;
  end

  // Reset loads the documented parameter defaults
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= reset_state;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a plain copy of a state flop
  assign reg_rdata = s_q.rd_data;
  assign result_valid = s_q.result_valid;
  assign result_channel = s_q.result_channel;
  assign result_value = s_q.result;
  assign channel_status = s_q.chan_status;
  assign ir_recovery_busy = s_q.rec_busy;
  assign ir_adc_start = s_q.ir_start;
  assign ir_clock_divide = s_q.ir_div;
  assign irq = s_q.irq;

endmodule // sensor_param_block

// *** tb/sensor_param_chk.sv ***
`timescale 1ns/1ps
module sensor_param_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Observed ports
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic meas_valid,
  input wire logic meas_overrange,
  input wire logic result_valid,
  input wire logic [15:0] result_value,
  input wire logic [3:0] channel_status,
  input wire logic ir_request,
  input wire logic ir_recovery_busy,
  input wire logic ir_adc_start,
  input wire logic [7:0] ir_clock_divide
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence rec_taken;
    ir_request && !ir_recovery_busy;
  endsequence
  sequence rec_end;
    $past(ir_recovery_busy) && !ir_recovery_busy ##1 !ir_adc_start;
  endsequence
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside its slot");
  a_result_slot: assert property (
    meas_valid |=> result_valid) else $error("no result after sample");
  a_no_stray: assert property (
    !meas_valid |=> !result_valid) else $error("result without sample");
  a_overrange_code: assert property (
    meas_valid && meas_overrange |=> result_value == 16'hFFFF) else $error("overrange lost");
  a_valid_distinct: assert property (
    meas_valid && !meas_overrange |=> result_value != 16'hFFFF) else $error("valid is all ones");
  a_status_hold: assert property (
    !$past(meas_valid) |-> $stable(channel_status)) else $error("status moved without sample");
  a_recovery_min: assert property (
    rec_taken |=> ir_recovery_busy [*6]) else $error("recovery too short");
  a_start_closes: assert property (
    ir_adc_start |-> rec_end) else $error("start pulse not closing recovery");
  a_divide_power: assert property (
    $onehot(ir_clock_divide)) else $error("clock divide not a power of two");
endmodule // sensor_param_chk

bind sensor_param_block sensor_param_chk i_chk (
  .core_clk(core_clk),
  .rst(rst),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .meas_valid(meas_valid),
  .meas_overrange(meas_overrange),
  .result_valid(result_valid),
  .result_value(result_value),
  .channel_status(channel_status),
  .ir_request(ir_request),
  .ir_recovery_busy(ir_recovery_busy),
  .ir_adc_start(ir_adc_start),
  .ir_clock_divide(ir_clock_divide)
);

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import sensor_param_pkg::*;
  logic core_clk, rst, reg_wr, reg_rd, meas_valid, meas_overrange, ir_request;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ir_clock_divide;
  logic [2:0] meas_channel, result_channel;
  logic signed [15:0] meas_delta;
  logic result_valid, ir_recovery_busy, ir_adc_start, irq;
  logic [15:0] result_value;
  logic [3:0] channel_status;
  int n_mismatch, checks, seed, offset_m, k, n;
  logic [7:0] ra [7] = '{8'h17, 8'h18, 8'h19, 8'h1A, 8'h1C, 8'h1D, 8'h1B};
  logic [7:0] rv [7] = '{8'h48, 8'h03, 8'h03, 8'h80, 8'h00, 8'h70, 8'h00};
  logic [7:0] oc [5] = '{8'h60, 8'h70, 8'hFF, 8'h00, 8'h80};
  logic [5:0] ic [5] = '{6'h00, 6'h09, 6'h38, 6'h07, 6'h11};

  sensor_param_block i_sensor_param_block (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_valid(meas_valid),
    .meas_channel(meas_channel), .meas_delta(meas_delta), .meas_overrange(meas_overrange),
    .result_valid(result_valid), .result_channel(result_channel),
    .result_value(result_value), .channel_status(channel_status), .ir_request(ir_request),
    .ir_recovery_busy(ir_recovery_busy), .ir_adc_start(ir_adc_start),
    .ir_clock_divide(ir_clock_divide), .irq(irq));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic int dec(int c);
    return ((16 + c % 16) << (c / 16)) >> 4;
  endfunction

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask

  // Model clamps into 0..0xFFFE so a valid sum never reads as overrange
  task automatic sample(logic [2:0] ch, logic signed [15:0] d, logic ovr);
    int s;
    @(posedge core_clk);
    meas_valid <= 1'b1;
    meas_channel <= ch;
    meas_delta <= d;
    meas_overrange <= ovr;
    @(posedge core_clk);
    meas_valid <= 1'b0;
    #1;
    s = int'(d) + offset_m;
    s = ovr ? 65535 : (s < 0 ? 0 : (s > 65534 ? 65534 : s));
    chk("result_valid", 16'h0001, {15'h0, result_valid});
    chk("result_value", s[15:0], result_value);
    chk("result_channel", {13'h0, ch}, {13'h0, result_channel});
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Longest path is the recovery table, a few thousand cycles
  initial begin
    #500000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    seed = 32'hab6f;
    {rst, reg_wr, reg_rd, meas_valid, meas_overrange, ir_request} = 6'b100000;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    meas_channel = 3'h0;
    meas_delta = 16'sh0000;
    offset_m = 256;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(addr_emit_rec, 8'hA5);
    rd(addr_emit_rec, 8'hA5);
    wr(addr_ir_rec, 8'hFF);
    rd(addr_ir_rec, 8'h70);
    $display("test registers done");
    foreach (oc[i]) begin
      wr(addr_meas_offset, oc[i]);
      offset_m = dec(oc[i]);
      sample(chan_ambient_ir, 16'sh8000, 1'b0);
      repeat (4) sample(chan_ambient_ir, 16'($random(seed)), 1'b0);
      sample(chan_ambient_ir, 16'sh7FFF, 1'b0);
    end
    $display("test offset done");
    wr(addr_irq_enable, 8'h01);
    wr(8'h20, 8'hE8);
    wr(8'h21, 8'h03);
    wr(8'h28, 8'hE8);
    wr(8'h29, 8'h03);
    wr(addr_prox_pers, 8'h07);
    // Result 1024 sits exactly on threshold plus hysteresis
    repeat (3) sample(3'h0, 16'sd768, 1'b0);
    chk("channel_status", 16'h0000, {12'h0, channel_status});
    for (int c = 0; c < 2; c++) begin
      n = c ? 8 : 3;
      wr(c ? addr_amb_pers : addr_prox_pers, c ? 8'hFF : 8'h07);
      for (int i = 1; i <= n; i++) begin
        sample(c ? chan_ambient_vis : 3'h0, 16'sd800, 1'b0);
        chk("channel_status", {12'h0, c == 1 && i >= n, 2'b00, c == 1 || i >= n},
            {12'h0, channel_status});
      end
      rd(addr_irq_status, c ? 8'h08 : 8'h01);
      chk("irq", {15'h0, c == 0}, {15'h0, irq});
      wr(addr_irq_clear, 8'h01);
    end
    wr(addr_irq_enable, 8'h10);
    sample(chan_ambient_ir, 16'sh0000, 1'b1);
    rd(addr_irq_status, 8'h18);
    chk("irq", 16'h0001, {15'h0, irq});
    // Result 976 plus hysteresis sits exactly on the threshold: no release
    repeat (3) sample(3'h0, 16'sd720, 1'b0);
    chk("channel_status", 16'h0009, {12'h0, channel_status});
    repeat (3) sample(3'h0, 16'sd700, 1'b0);
    chk("channel_status", 16'h0008, {12'h0, channel_status});
    rd(addr_chan_status, 8'h08);
    rd(addr_result_lo, 8'hBC);
    rd(addr_result_hi, 8'h03);
    rd(addr_irq_status, 8'h19);
    rd(addr_irq_enable, 8'h10);
    rd(addr_irq_clear, 8'h00);
    rd(8'h29, 8'h03);
    $display("test filter done");
    foreach (ic[i]) begin
      wr(addr_ir_rec, {1'b1, ic[i][5:3], 4'hF});
      wr(addr_ir_gain, {5'h00, ic[i][2:0]});
      @(posedge core_clk);
      ir_request <= 1'b1;
      @(posedge core_clk);
      ir_request <= 1'b0;
      k = 0;
      do begin
        @(posedge core_clk);
        k++;
        #1;
      end while (ir_adc_start !== 1'b1 && k < 70000);
      n = ((ic[i][5:3] == 3'h0) ? 1 : (4 << ic[i][5:3]) - 1) * 5 << ic[i][2:0];
      chk("recovery cycles", 16'(n + 1), 16'(k));
      chk("ir_clock_divide", 16'h0001 << ic[i][2:0], {8'h0, ir_clock_divide});
    end
    rd(addr_ir_gain, 8'h01);
    rd(addr_ir_rec, 8'h20);
    $display("test recovery done");
    finish_test();
  end
endmodule // testbench
